// *** src/cpic_defs.vh ***
// cpic_defs.vh: constants for the cascaded priority interrupt controller
// assumes inclusion by the design file only; definitions only
`ifndef CPIC_DEFS_VH
`define CPIC_DEFS_VH

// ****************************************
// port addresses
// ****************************************
`define CPIC_MASTER_CMD    16'h0020
`define CPIC_MASTER_DATA   16'h0021
`define CPIC_SLAVE_CMD     16'h00A0
`define CPIC_SLAVE_DATA    16'h00A1

// ****************************************
// command byte fields
// ****************************************
`define CPIC_INIT1_BIT     4
`define CPIC_SEL3_BIT      3
`define CPIC_OC3_RR_BIT    1
`define CPIC_OC3_RIS_BIT   0
`define CPIC_OC3_ESMM_BIT  6
`define CPIC_OC3_SMM_BIT   5
`define CPIC_OC3_POLL_BIT  2
`define CPIC_OC2_EOI_BIT   5
`define CPIC_OC2_SL_BIT    6
`define CPIC_OC2_ROT_BIT   7
`define CPIC_INIT4_SFN_BIT 4
`define CPIC_VEC_BASE_MSK  8'hF8

// ****************************************
// reset values and fixed levels
// ****************************************
`define CPIC_ZERO8         8'h00
`define CPIC_SPURIOUS_LVL  3'h7
`define CPIC_CASCADE_LVL   3'h2
`define CPIC_REDIRECT_LVL  3'h1
`define CPIC_POLL_PRESENT  8'h80

// ****************************************
// initialization sequence states
// ****************************************
`define CPIC_ST_READY      2'h0
`define CPIC_ST_INIT2      2'h1
`define CPIC_ST_INIT3      2'h2
`define CPIC_ST_INIT4      2'h3

`endif

// *** src/cpic_top.v ***
// cpic_top.v: master and slave eight-level units cascaded into fifteen levels
// assumes bus strobes and acknowledge pulses are one-cycle and synchronous to CLOCK
`timescale 1ns/1ns
`include "cpic_defs.vh"

// ****************************************
// eight-level unit
// ****************************************
// Summary of operation
// - fully-nested ranking: level 0 highest, level 7 lowest.
// - fully-nested is the mode in force after initialization unless the fourth byte sets special fully-nested.
// - each active request input sets its pending-request bit.
// - a mask bit blocks only its own level.
// - unmasked pending request above in-service level raises interrupt output.
// - first acknowledge moves winner into in-service; data bus undriven.
// - no request at acknowledge answers as level 7.
// - second acknowledge drives the vector on the data bus.
// - in-service bit holds until end-of-service; blocks same and lower levels.
// - nonspecific end-of-service clears highest set in-service bit.
// - specific end-of-service clears exactly the named level.
// - special mask mode: nonspecific end-of-service skips masked in-service bits.
// - read-register command selects pending or in-service; selection persists.
// - after initialization command port reads pending requests.
// - data port read returns the mask register.
// - special fully-nested master still forwards higher slave requests.
// - special fully-nested enabled by the fourth initialization byte.
// - expansion level 2 request routed to slave level 9 input.
// - requests are high levels only; edge programming stays level.
// - starting initialization clears the mask register.
module cpic_unit
(
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] irq,
  input  wire       wr_cmd,
  input  wire       wr_data,
  input  wire       rd_cmd,
  input  wire [7:0] din,
  input  wire       ack1,
  input  wire       ack2,
  output reg  [7:0] rd_val,
  output reg  [7:0] vec_val,
  output reg        int_q,
  output reg        cas_win
);

  reg  [1:0] st_q;
  reg  [7:0] irr_q;
  reg  [7:0] isr_q;
  reg  [7:0] imr_q;
  reg  [7:0] base_q;
  reg  [2:0] prio_q;
  reg        rd_isr_q;
  reg        smm_q;
  reg        sfn_q;
  reg        poll_q;
  reg  [2:0] ack_lvl_q;
  reg  [7:0] req;
  reg  [7:0] isr_vis;
  reg  [3:0] req_best;
  reg  [3:0] isr_best;
  reg  [3:0] eoi_best;
  reg  [7:0] isr_d;

  // highest active level in rotated order; bit 3 flags none found
  function [3:0] pick;
    input [7:0] v;
    input [2:0] low;
    integer     k;
    reg   [2:0] l;
    reg   [3:0] r;
    begin
      r = 4'h8;
      for (k = 7; k >= 0; k = k - 1)
      begin
        l = low + 3'h1 + k[2:0];
        if (v[l])
          r = {1'b0, l};
      end
      pick = r;
    end
  endfunction

  // priority position of a level, 0 the highest
  function [2:0] rank;
    input [2:0] l;
    input [2:0] low;
    begin
      rank = l - low - 3'h1;
    end
  endfunction

  // priority resolution
  always @*
  begin
    req      = irr_q & ~imr_q;
    isr_vis  = smm_q ? (isr_q & ~imr_q) : isr_q;
    // special fully-nested: in-service cascade level does not block itself
    if (sfn_q)
      isr_vis[`CPIC_CASCADE_LVL] = 1'b0;
    req_best = pick(req, prio_q);
    isr_best = pick(isr_vis, prio_q);
    eoi_best = pick(smm_q ? (isr_q & ~imr_q) : isr_q, prio_q);
    cas_win  = req_best == {1'b0, `CPIC_CASCADE_LVL};
  end

  // in-service next value from acknowledge and end-of-service
  always @*
  begin
    isr_d = isr_q;
    if (wr_cmd && st_q == `CPIC_ST_READY && !din[`CPIC_INIT1_BIT] &&
        !din[`CPIC_SEL3_BIT] && din[`CPIC_OC2_EOI_BIT])
    begin
      if (din[`CPIC_OC2_SL_BIT])
        isr_d[din[2:0]] = 1'b0;
      else if (!eoi_best[3])
        isr_d[eoi_best[2:0]] = 1'b0;
    end
    // acknowledge applied last so a same-cycle set is never lost
    if (ack1 && !req_best[3])
      isr_d[req_best[2:0]] = 1'b1;
  end

  // registers and command decoding
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q      <= `CPIC_ST_READY;
      irr_q     <= `CPIC_ZERO8;
      isr_q     <= `CPIC_ZERO8;
      imr_q     <= `CPIC_ZERO8;
      base_q    <= `CPIC_ZERO8;
      prio_q    <= `CPIC_SPURIOUS_LVL;
      rd_isr_q  <= 1'b0;
      smm_q     <= 1'b0;
      sfn_q     <= 1'b0;
      poll_q    <= 1'b0;
      ack_lvl_q <= `CPIC_SPURIOUS_LVL;
      int_q     <= 1'b0;
    end
    else
    begin
      irr_q <= irq;
      isr_q <= isr_d;
      int_q <= !req_best[3] &&
               (isr_best[3] || rank(req_best[2:0], prio_q) <
                rank(isr_best[2:0], prio_q));
      if (ack1)
        ack_lvl_q <= req_best[3] ? `CPIC_SPURIOUS_LVL : req_best[2:0];
      if (rd_cmd && poll_q)
        poll_q <= 1'b0;
      if (wr_cmd && din[`CPIC_INIT1_BIT])
      begin
        // initialization start: reset modes to fully nested
        st_q     <= `CPIC_ST_INIT2;
        imr_q    <= `CPIC_ZERO8;
        prio_q   <= `CPIC_SPURIOUS_LVL;
        rd_isr_q <= 1'b0;
        smm_q    <= 1'b0;
        sfn_q    <= 1'b0;
      end
      else if (wr_cmd && st_q == `CPIC_ST_READY)
      begin
        if (din[`CPIC_SEL3_BIT])
        begin
          if (din[`CPIC_OC3_RR_BIT])
            rd_isr_q <= din[`CPIC_OC3_RIS_BIT];
          if (din[`CPIC_OC3_ESMM_BIT])
            smm_q <= din[`CPIC_OC3_SMM_BIT];
          poll_q <= din[`CPIC_OC3_POLL_BIT];
        end
        else if (din[`CPIC_OC2_ROT_BIT])
        begin
          if (din[`CPIC_OC2_SL_BIT])
            prio_q <= din[2:0];
          else if (!eoi_best[3] && din[`CPIC_OC2_EOI_BIT])
            prio_q <= eoi_best[2:0];
        end
      end
      else if (wr_data)
      begin
        case (st_q)
          `CPIC_ST_READY: imr_q  <= din;
          `CPIC_ST_INIT2:
          begin
            base_q <= din & `CPIC_VEC_BASE_MSK;
            st_q   <= `CPIC_ST_INIT3;
          end
          `CPIC_ST_INIT3: st_q   <= `CPIC_ST_INIT4;
          `CPIC_ST_INIT4:
          begin
            sfn_q <= din[`CPIC_INIT4_SFN_BIT];
            st_q  <= `CPIC_ST_READY;
          end
          default:        st_q   <= `CPIC_ST_READY;
        endcase
      end
    end
  end

  // read data selection; poll answers with present flag and level
  always @*
  begin
    if (wr_data)
      rd_val = imr_q;
    else
      rd_val = imr_q;
    if (rd_cmd)
    begin
      if (poll_q)
        rd_val = req_best[3] ? {5'h00, `CPIC_SPURIOUS_LVL} :
                 (`CPIC_POLL_PRESENT | {5'h00, req_best[2:0]});
      else
        rd_val = rd_isr_q ? isr_q : irr_q;
    end
    vec_val = base_q | {5'h00, ack_lvl_q};
  end

endmodule

// ****************************************
// top: two cascaded units and port decode
// ****************************************
module cpic_top
(
  input  wire        CLOCK,
  input  wire        RST,
  input  wire [7:0]  MASTER_IRQ,
  input  wire [7:0]  SLAVE_IRQ,
  input  wire        EXP_IRQ2,
  input  wire [15:0] ADDR,
  input  wire        WR_STB,
  input  wire        RD_STB,
  input  wire [7:0]  DATA_IN,
  input  wire        INTA_STB,
  output reg  [7:0]  DATA_OUT,
  output reg         DATA_OE,
  output reg         INT_OUT
);

  reg        ack_second_q;
  reg        slave_ack_q;
  wire       hit_mc;
  wire       hit_md;
  wire       hit_sc;
  wire       hit_sd;
  wire       ack1;
  wire       ack2;
  wire       m_int;
  wire       m_cas;
  wire       s_int;
  wire [7:0] m_rd;
  wire [7:0] s_rd;
  wire [7:0] m_vec;
  wire [7:0] s_vec;
  wire [7:0] m_irq;
  wire [7:0] s_irq;

  assign hit_mc = ADDR == `CPIC_MASTER_CMD;
  assign hit_md = ADDR == `CPIC_MASTER_DATA;
  assign hit_sc = ADDR == `CPIC_SLAVE_CMD;
  assign hit_sd = ADDR == `CPIC_SLAVE_DATA;
  assign ack1   = INTA_STB && !ack_second_q;
  assign ack2   = INTA_STB && ack_second_q;

  // cascade into level 2; expansion level 2 redirected to slave level 9
  assign m_irq = {MASTER_IRQ[7:3], s_int, MASTER_IRQ[1:0]};
  assign s_irq = {SLAVE_IRQ[7:2], SLAVE_IRQ[1] | EXP_IRQ2, SLAVE_IRQ[0]};

  cpic_unit u_master
  (
    .clk     (CLOCK),
    .rst     (RST),
    .irq     (m_irq),
    .wr_cmd  (WR_STB && hit_mc),
    .wr_data (WR_STB && hit_md),
    .rd_cmd  (RD_STB && hit_mc),
    .din     (DATA_IN),
    .ack1    (ack1),
    .ack2    (ack2),
    .rd_val  (m_rd),
    .vec_val (m_vec),
    .int_q   (m_int),
    .cas_win (m_cas)
  );

  cpic_unit u_slave
  (
    .clk     (CLOCK),
    .rst     (RST),
    .irq     (s_irq),
    .wr_cmd  (WR_STB && hit_sc),
    .wr_data (WR_STB && hit_sd),
    .rd_cmd  (RD_STB && hit_sc),
    .din     (DATA_IN),
    .ack1    (ack1 && m_cas),
    .ack2    (ack2 && slave_ack_q),
    .rd_val  (s_rd),
    .vec_val (s_vec),
    .int_q   (s_int),
    .cas_win ()
  );

  // acknowledge pulse pairing and registered bus outputs
  always @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ack_second_q <= 1'b0;
      slave_ack_q  <= 1'b0;
      DATA_OUT     <= `CPIC_ZERO8;
      DATA_OE      <= 1'b0;
      INT_OUT      <= 1'b0;
    end
    else
    begin
      INT_OUT <= m_int;
      if (INTA_STB)
        ack_second_q <= !ack_second_q;
      if (ack1)
        slave_ack_q <= m_cas;
      DATA_OE  <= 1'b0;
      DATA_OUT <= `CPIC_ZERO8;
      if (ack2)
      begin
        DATA_OE  <= 1'b1;
        DATA_OUT <= slave_ack_q ? s_vec : m_vec;
      end
      else if (RD_STB && (hit_mc || hit_md))
      begin
        DATA_OE  <= 1'b1;
        DATA_OUT <= m_rd;
      end
      else if (RD_STB && (hit_sc || hit_sd))
      begin
        DATA_OE  <= 1'b1;
        DATA_OUT <= s_rd;
      end
    end
  end

endmodule

// *** testbench/cpic_props.sv ***
// cpic_props.sv: port checker for cpic_top
// assumes one-cycle strobes and answers registered on the strobe edge
`timescale 1ns/1ns
// ****************************************
// checker
// ****************************************
module cpic_props
(
  input wire        CLOCK,
  input wire        RST,
  input wire [7:0]  MASTER_IRQ,
  input wire [7:0]  SLAVE_IRQ,
  input wire        EXP_IRQ2,
  input wire [15:0] ADDR,
  input wire        RD_STB,
  input wire        INTA_STB,
  input wire        DATA_OE,
  input wire        INT_OUT
);
  reg  ph_q;
  wire map_w;
  wire req_w;
  wire any_w;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // decode and request summary
  assign map_w = (ADDR[15:8] == 8'h00) && ((ADDR[7:1] == 7'h10) || (ADDR[7:1] == 7'h50));
  assign req_w = (|MASTER_IRQ) || (|SLAVE_IRQ) || EXP_IRQ2;
  assign any_w = RD_STB || INTA_STB;
  // high while the next acknowledge is the second of a pair
  always @(posedge CLOCK or posedge RST)
    if (RST)
      ph_q <= 1'b0;
    else if (INTA_STB)
      ph_q <= ~ph_q;
  property p_rd_oe; RD_STB && map_w && !INTA_STB |=> DATA_OE; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("mapped read gave no data");
  property p_unmap; RD_STB && !map_w && !INTA_STB |=> !DATA_OE; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read drove bus");
  property p_ack1; INTA_STB && !ph_q && !RD_STB |=> !DATA_OE; endproperty
  a_ack1: assert property (p_ack1) else $error("first ack drove bus");
  property p_ack2; INTA_STB && ph_q |=> DATA_OE; endproperty
  a_ack2: assert property (p_ack2) else $error("second ack gave no vector");
  property p_oe_src; DATA_OE |-> $past(any_w); endproperty
  a_oe_src: assert property (p_oe_src) else $error("bus driven without cause");
  property p_oe_one; DATA_OE && !any_w |=> !DATA_OE; endproperty
  a_oe_one: assert property (p_oe_one) else $error("bus held too long");
  property p_int_src; $rose(INT_OUT) |-> $past(req_w, 3); endproperty
  a_int_src: assert property (p_int_src) else $error("interrupt without request");
  property p_int_idle; !req_w [*4] |=> !INT_OUT; endproperty
  a_int_idle: assert property (p_int_idle) else $error("interrupt with no level");
endmodule

bind cpic_top cpic_props u_props
(
  .CLOCK      (CLOCK),
  .RST        (RST),
  .MASTER_IRQ (MASTER_IRQ),
  .SLAVE_IRQ  (SLAVE_IRQ),
  .EXP_IRQ2   (EXP_IRQ2),
  .ADDR       (ADDR),
  .RD_STB     (RD_STB),
  .INTA_STB   (INTA_STB),
  .DATA_OE    (DATA_OE),
  .INT_OUT    (INT_OUT)
);

// *** testbench/cpic_cpu_model.sv ***
// cpic_cpu_model.sv: processor side, port cycles and acknowledges
// assumes answers are registered on the edge that takes the strobe
`timescale 1ns/1ns
// ****************************************
// processor model
// ****************************************
module cpic_cpu_model
(
  input  wire        CLOCK,
  input  wire [7:0]  DATA_OUT,
  input  wire        DATA_OE,
  output reg  [15:0] ADDR,
  output reg         WR_STB,
  output reg         RD_STB,
  output reg  [7:0]  DATA_IN,
  output reg         INTA_STB
);
  // idle bus at time zero
  initial
  begin
    ADDR = 16'h0000;
    DATA_IN = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    INTA_STB = 1'b0;
  end
  // one strobe held for one edge; answer taken after that edge
  task cyc(input [15:0] a, input [7:0] d, input w, input r, input k,
           output [7:0] q, output oe);
  begin
    @(posedge CLOCK);
    #1;
    ADDR = a;
    DATA_IN = d;
    WR_STB = w;
    RD_STB = r;
    INTA_STB = k; // acks always issued as pairs
    @(posedge CLOCK);
    #1;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
    INTA_STB = 1'b0;
    ADDR = ~a; // released bus shows no stale value
    DATA_IN = ~d;
    q = DATA_OUT; // registered answer stands this one cycle
    oe = DATA_OE;
  end
  endtask
endmodule

// *** testbench/cascaded_priority_interrupt_controller_tb_top.sv ***
// cascaded_priority_interrupt_controller_tb_top.sv: directed bench
// assumes cpic_top, cpic_cpu_model and the bound checker
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module cascaded_priority_interrupt_controller_tb_top;
  reg         CLOCK;
  reg         RST;
  reg  [7:0]  MASTER_IRQ;
  reg  [7:0]  SLAVE_IRQ;
  reg         EXP_IRQ2;
  wire [15:0] ADDR;
  wire        WR_STB;
  wire        RD_STB;
  wire [7:0]  DATA_IN;
  wire        INTA_STB;
  wire [7:0]  DATA_OUT;
  wire        DATA_OE;
  wire        INT_OUT;
  integer     err_total;
  integer     check_count;
  integer     cyc_n;
  reg  [7:0]  q;
  reg         o;
  cpic_top dut (.CLOCK(CLOCK), .RST(RST), .MASTER_IRQ(MASTER_IRQ), .SLAVE_IRQ(SLAVE_IRQ),
    .EXP_IRQ2(EXP_IRQ2), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .DATA_IN(DATA_IN),
    .INTA_STB(INTA_STB), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .INT_OUT(INT_OUT));
  cpic_cpu_model m (.CLOCK(CLOCK), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .ADDR(ADDR),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .DATA_IN(DATA_IN), .INTA_STB(INTA_STB));
  // clock and cycle ceiling
  initial
  begin
    CLOCK = 1'b0;
    cyc_n = 0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK)
  begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 3000)
    begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input string n, input [7:0] e, input [7:0] s);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    m.cyc(a, d, 1'b1, 1'b0, 1'b0, q, o);
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    m.cyc(a, 8'h00, 1'b0, 1'b1, 1'b0, q, o);
    chk("read_oe", {7'h00, a[7:0] != 8'h22}, {7'h00, o});
    if (a[7:0] != 8'h22)
      chk("read_data", e, q);
  end
  endtask
  task ack(input [7:0] e);
  begin
    m.cyc(16'h0000, 8'h00, 1'b0, 1'b0, 1'b1, q, o);
    chk("ack1_oe", 8'h00, {7'h00, o});
    m.cyc(16'h0000, 8'h00, 1'b0, 1'b0, 1'b1, q, o);
    chk("vector", e, q);
  end
  endtask
  task wint(input e);
  begin
    repeat (6) @(posedge CLOCK);
    #1;
    chk("int_out", {7'h00, e}, {7'h00, INT_OUT});
  end
  endtask
  // main sequence
  initial
  begin
    RST = 1'b1;
    MASTER_IRQ = 8'h00;
    SLAVE_IRQ = 8'h00;
    EXP_IRQ2 = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    wr(16'h0020, 8'h19);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h00); // fully nested by default
    wr(16'h00A0, 8'h19);
    wr(16'h00A1, 8'h70);
    wr(16'h00A1, 8'h02);
    wr(16'h00A1, 8'h00);
    rd(16'h0021, 8'h00);
    rd(16'h0020, 8'h00);
    wr(16'h00A1, 8'hA5);
    rd(16'h00A1, 8'hA5);
    rd(16'h0022, 8'h00); // unmapped, no answer
    wr(16'h00A1, 8'h00);
    MASTER_IRQ = 8'h28;
    wint(1'b1);
    rd(16'h0020, 8'h28);
    ack(8'h0B);
    wr(16'h0020, 8'h0B);
    rd(16'h0020, 8'h08);
    wint(1'b0);
    MASTER_IRQ = 8'h2A;
    wint(1'b1);
    ack(8'h09);
    MASTER_IRQ = 8'h00;
    rd(16'h0020, 8'h0A);
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h08);
    wr(16'h0020, 8'h63);
    rd(16'h0020, 8'h00);
    wr(16'h0021, 8'h08);
    MASTER_IRQ = 8'h28;
    wint(1'b1);
    ack(8'h0D);
    MASTER_IRQ = 8'h00;
    wr(16'h0020, 8'h20);
    wr(16'h0021, 8'h00);
    MASTER_IRQ = 8'h10;
    wint(1'b1);
    MASTER_IRQ = 8'h00;
    wint(1'b0);
    ack(8'h0F);
    rd(16'h0020, 8'h00);
    EXP_IRQ2 = 1'b1;
    rd(16'h00A0, 8'h02);
    wint(1'b1);
    ack(8'h71);
    EXP_IRQ2 = 1'b0;
    wr(16'h00A0, 8'h0B);
    rd(16'h00A0, 8'h02);
    wr(16'h00A0, 8'h20); // slave cleared first
    rd(16'h00A0, 8'h00);
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h00);
    // re-initialise master with special fully nested
    wr(16'h0021, 8'hFF);
    wr(16'h0020, 8'h19); // no acknowledges while programming
    rd(16'h0021, 8'h00);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h10);
    SLAVE_IRQ = 8'h02;
    wint(1'b1);
    ack(8'h71);
    wint(1'b0);
    SLAVE_IRQ = 8'h03;
    wint(1'b1);
    ack(8'h70);
    SLAVE_IRQ = 8'h00;
    wr(16'h00A0, 8'h20);
    rd(16'h00A0, 8'h02);
    wr(16'h00A0, 8'h20);
    rd(16'h00A0, 8'h00);
    // special mask mode keeps a masked in-service level
    wr(16'h0021, 8'h04);
    wr(16'h0020, 8'h68);
    wr(16'h0020, 8'h20);
    wr(16'h0020, 8'h0B);
    rd(16'h0020, 8'h04);
    wr(16'h0020, 8'h48);
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h00);
    wr(16'h0021, 8'h00);
    complete_run;
  end
endmodule
